// File: qsm_pkg.sv
// shared constants for the quad serial master with transmit, receive and match modes
package qsm_pkg;
   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_HDR = 8'h04;
   localparam logic [7:0] OFS_LEN = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam logic [7:0] OFS_BUF = 8'h10;
   localparam logic [7:0] OFS_BUF_NBS = 8'h14;

   // ****************************************
   // control and status fields
   // ****************************************
   localparam int CTRL_START = 0;
   localparam int CTRL_CPHA = 1;
   localparam int CTRL_MODE_LO = 4;
   localparam int CTRL_PW_LO = 8;
   localparam int STAT_BUSY = 0;
   localparam int STAT_NOT_FULL = 1;
   localparam int STAT_EMPTY = 2;
   localparam int STAT_MATCH = 3;

   // ****************************************
   // reset values and encodings
   // ****************************************
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_TX = 2'h1;
   localparam logic [1:0] MODE_RX = 2'h2;
   localparam logic [1:0] MODE_MATCH = 2'h3;
   localparam logic [2:0] PW_QUAD = 3'h3;
   localparam logic [2:0] PW_DUAL = 3'h1;
   localparam logic [31:0] HDR_RESET = 32'h0000_0000;
   localparam logic [15:0] LEN_RESET = 16'h0000;

   // ****************************************
   // frame shape, in bits
   // ****************************************
   localparam int WORD_BITS = 32;
   localparam int HDR_BITS = 32;
   localparam int DUMMY_BITS = 8;
   localparam int LANES = 4;

   // ****************************************
   // timing: half period of the serial clock
   // ****************************************
   localparam int CLK_MHZ = 100;
   localparam int SCK_HALF_NS = 40;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [2:0] {
      QSM_IDLE, QSM_HDR, QSM_DUM1, QSM_PAY, QSM_DUM2, QSM_HOLD
   } qsm_state_t;
endpackage : qsm_pkg

// File: qsm_stream_if.sv
// valid/ready word stream between the bus side and the shifter
`timescale 1ns/10ps
interface qsm_stream_if #(
   parameter int W = 32
);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : qsm_stream_if

// File: qsm_fifo2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module qsm_fifo2 #(
   parameter int W = 32
) (
   input wire logic hclk,
   input wire logic hresetn,
   qsm_stream_if.snk in_s,
   qsm_stream_if.src out_s
);
   logic [W-1:0] mem_q [2];
   logic wp_q;
   logic rp_q;
   logic [1:0] cnt_q;
   logic push;
   logic pop;

   // full and empty straight from the count
   assign in_s.ready = (cnt_q != 2'd2);
   assign out_s.valid = (cnt_q != 2'd0);
   assign out_s.data = mem_q[rp_q];
   assign push = in_s.valid && in_s.ready;
   assign pop = out_s.valid && out_s.ready;

   // storage, no reset needed on data
   always_ff @(posedge hclk) begin
      if (push) begin
         mem_q[wp_q] <= in_s.data;
      end
   end

   // pointers and fill level
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'd0;
      end else begin
         if (push) wp_q <= ~wp_q;
         if (pop) rp_q <= ~rp_q;
         cnt_q <= cnt_q + 2'(push) - 2'(pop);
      end
   end
endmodule : qsm_fifo2

// File: qsm_tx_top.sv
// quad serial master: ahb-lite registers, two timers and two 32-bit shifters
//
// Overview of operation
// - a frame opens with one command byte and three address bytes before any payload.
// - one dummy byte is sent right before the payload and another right after it.
// - the shifter works as the transmitter and is paced by the clock timer.
// - with the default phase the lanes change on the falling serial clock edge.
// - lane width field 3 moves four bits per serial clock on all four lanes after the header.
// - default phase: no start bit, data loaded when the timer starts, no stop bit.
// - second-edge phase: update on the rising edge, load on first shift, low stop bit.
// - the two 32-bit shifters support transmit, receive and match modes.
// - in transmit mode each word comes from the buffer and goes out on the lanes.
// - the swapped alias shares the buffer and swaps nibbles on read and write.
// - a read of the alias returns bits 27:24,31:28,19:16,23:20,11:8,15:12,3:0,7:4.
// - the clock timer makes the serial clock and paces load, store and shift.
// - the select timer holds chip select asserted for the whole frame.
`timescale 1ns/10ps
module qsm_tx_top #(
   parameter int SCK_HALF = qsm_pkg::SCK_HALF_CYC,
   parameter int LEN_W = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [3:0] in_lane,
   output logic sck,
   output logic cs_n,
   output logic [3:0] out_lane
);
   // ****************************************
   // elaboration checks
   // ****************************************
   if (SCK_HALF < 1 || SCK_HALF > 255) begin : g_bad_div
      $error("SCK_HALF out of range");
   end
   if (LEN_W < 1 || LEN_W > 16) begin : g_bad_len
      $error("LEN_W out of range");
   end

   // ****************************************
   // declarations
   // ****************************************
   qsm_pkg::qsm_state_t state_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   logic hresp_q;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic cpha_q;
   logic [1:0] mode_q;
   logic [2:0] pw_q;
   logic [31:0] hdr_q;
   logic [LEN_W-1:0] len_q;
   logic [31:0] shift_buf_q;
   logic match_q;
   logic [31:0] sh_q;
   logic [31:0] rx_sh_q;
   logic [5:0] cnt_q;
   logic [LEN_W-1:0] words_q;
   logic [7:0] div_q;
   logic sck_q;
   logic cs_n_q;
   logic [3:0] lanes_q;
   logic [3:0] in_s1_q;
   logic [3:0] in_s2_q;
   logic addr_ok;
   logic start;
   logic push_req;
   logic [31:0] push_word;
   logic [1:0] lg;
   logic [1:0] lg_run;
   logic [3:0] cur_bits;
   logic active;
   logic need_word;
   logic block;
   logic tick;
   logic rise_ev;
   logic fall_ev;
   logic seg_end;
   logic [31:0] nbs_rd;
   logic [31:0] nbs_wr;
   logic [31:0] hdr_rev;

   qsm_stream_if #(.W(32)) wr_s ();
   qsm_stream_if #(.W(32)) rd_s ();

   // ****************************************
   // nibble swap within each byte
   // ****************************************
   // same swap both ways: one function serves read and write
   function automatic logic [31:0] nib_swap(input logic [31:0] v);
      logic [31:0] r;
      r = '0;
      for (int b = 0; b < 4; b++) begin
         r[b*8 +: 4] = v[b*8+4 +: 4];
         r[b*8+4 +: 4] = v[b*8 +: 4];
      end
      return r;
   endfunction : nib_swap

   assign nbs_rd = nib_swap(shift_buf_q);
   assign nbs_wr = nib_swap(hwdata);
   assign hdr_rev = {<<{hdr_q}}; // header goes msb first on lane 0

   // ****************************************
   // ahb-lite slave
   // ****************************************
   assign addr_ok = hsel && htrans[1] && hready && hreadyout_q;
   assign push_req = wr_pend_q &&
      (wr_addr_q == qsm_pkg::OFS_BUF || wr_addr_q == qsm_pkg::OFS_BUF_NBS);
   assign push_word = (wr_addr_q == qsm_pkg::OFS_BUF_NBS) ? nbs_wr : hwdata;
   assign start = wr_pend_q && wr_addr_q == qsm_pkg::OFS_CTRL &&
      hwdata[qsm_pkg::CTRL_START] && state_q == qsm_pkg::QSM_IDLE &&
      hwdata[qsm_pkg::CTRL_MODE_LO +: 2] != qsm_pkg::MODE_OFF;

   // writes take one wait state; a full buffer stalls the bus until space appears
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_q <= 1'b1;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hresp_q <= 1'b0;
      end else begin
         if (wr_pend_q) begin
            if (!push_req || wr_s.ready) begin
               wr_pend_q <= 1'b0;
               hreadyout_q <= 1'b1;
            end
         end else if (addr_ok && hwrite) begin
            wr_pend_q <= 1'b1;
            wr_addr_q <= haddr;
            hreadyout_q <= 1'b0;
         end
      end
   end

   // read data captured in the address phase, zero for unmapped offsets
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h0000_0000;
      end else if (addr_ok && !hwrite) begin
         unique case (haddr)
            qsm_pkg::OFS_CTRL: hrdata_q <= {21'h0, pw_q, 2'h0, mode_q, 2'h0, cpha_q, 1'b0};
            qsm_pkg::OFS_HDR: hrdata_q <= hdr_q;
            qsm_pkg::OFS_LEN: hrdata_q <= 32'(len_q);
            qsm_pkg::OFS_STAT: hrdata_q <= {28'h0, match_q, ~rd_s.valid,
               wr_s.ready, state_q != qsm_pkg::QSM_IDLE};
            qsm_pkg::OFS_BUF: hrdata_q <= shift_buf_q;
            qsm_pkg::OFS_BUF_NBS: hrdata_q <= nbs_rd;
            default: hrdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // configuration registers; control changes mid-frame act at once, so set them while idle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpha_q <= 1'b0;
         mode_q <= qsm_pkg::MODE_TX;
         pw_q <= qsm_pkg::PW_QUAD;
         hdr_q <= qsm_pkg::HDR_RESET;
         len_q <= qsm_pkg::LEN_RESET[LEN_W-1:0];
      end else if (wr_pend_q) begin
         unique case (wr_addr_q)
            qsm_pkg::OFS_CTRL: begin
               cpha_q <= hwdata[qsm_pkg::CTRL_CPHA];
               mode_q <= hwdata[qsm_pkg::CTRL_MODE_LO +: 2];
               pw_q <= hwdata[qsm_pkg::CTRL_PW_LO +: 3];
            end
            qsm_pkg::OFS_HDR: hdr_q <= hwdata;
            qsm_pkg::OFS_LEN: len_q <= hwdata[LEN_W-1:0];
            default: ;
         endcase
      end
   end

   // buffer storage: receive store beats a bus write in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shift_buf_q <= 32'h0000_0000;
      end else if (seg_end && state_q == qsm_pkg::QSM_PAY && mode_q == qsm_pkg::MODE_RX) begin
         shift_buf_q <= rx_sh_q;
      end else if (push_req && wr_s.ready) begin
         shift_buf_q <= push_word;
      end
   end

   // match flag: set wins over a write-one clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         match_q <= 1'b0;
      end else if (seg_end && state_q == qsm_pkg::QSM_PAY &&
                   mode_q == qsm_pkg::MODE_MATCH && rx_sh_q == shift_buf_q) begin
         match_q <= 1'b1;
      end else if (wr_pend_q && wr_addr_q == qsm_pkg::OFS_STAT &&
                   hwdata[qsm_pkg::STAT_MATCH]) begin
         match_q <= 1'b0;
      end
   end

   // ****************************************
   // word buffer between bus and shifter
   // ****************************************
   assign wr_s.valid = push_req;
   assign wr_s.data = push_word;
   assign rd_s.ready = seg_end && need_word;

   qsm_fifo2 #(.W(32)) u_buf (
      .hclk(hclk),
      .hresetn(hresetn),
      .in_s(wr_s),
      .out_s(rd_s)
   );

   // ****************************************
   // input lane synchroniser
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_s1_q <= 4'h0;
         in_s2_q <= 4'h0;
      end else begin
         in_s1_q <= in_lane;
         in_s2_q <= in_s1_q;
      end
   end

   // ****************************************
   // lane width and current lane bits
   // ****************************************
   // log2 of bits per shift clock: 3 gives quad, 1 dual, others single
   assign lg = (pw_q == qsm_pkg::PW_QUAD) ? 2'd2 : (pw_q == qsm_pkg::PW_DUAL) ? 2'd1 : 2'd0;
   assign lg_run = (state_q == qsm_pkg::QSM_HDR) ? 2'd0 : lg;
   // low bits leave first, so bit 3 (nibble msb) lands on lane 3
   assign cur_bits = sh_q[3:0] & ((4'h1 << (4'h1 << lg_run)) - 4'h1);

   // ****************************************
   // timer 0: serial clock
   // ****************************************
   assign active = state_q inside {qsm_pkg::QSM_HDR, qsm_pkg::QSM_DUM1,
                                   qsm_pkg::QSM_PAY, qsm_pkg::QSM_DUM2};
   assign need_word = mode_q == qsm_pkg::MODE_TX &&
      ((state_q == qsm_pkg::QSM_DUM1 && len_q != '0) ||
       (state_q == qsm_pkg::QSM_PAY && words_q != '0));
   // starving: hold the clock high rather than send a stale word
   assign block = cnt_q == 6'd0 && need_word && !rd_s.valid;
   assign tick = active && div_q == 8'd0;
   assign rise_ev = tick && !sck_q;
   assign fall_ev = tick && sck_q && !block;
   assign seg_end = fall_ev && cnt_q == 6'd0;

   // half-period divider; also times the chip select hold after the frame
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q <= 8'h00;
         sck_q <= 1'b0;
      end else begin
         if (start) begin
            div_q <= 8'(SCK_HALF - 1);
         end else if (active || state_q == qsm_pkg::QSM_HOLD) begin
            if (div_q != 8'd0) begin
               div_q <= div_q - 8'd1;
            end else if (!(sck_q && block)) begin
               div_q <= 8'(SCK_HALF - 1);
            end
         end
         if (rise_ev) sck_q <= 1'b1;
         else if (fall_ev) sck_q <= 1'b0;
      end
   end

   // ****************************************
   // timer 1: chip select over the frame
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cs_n_q <= 1'b1;
      end else if (start) begin
         cs_n_q <= 1'b0;
      end else if (state_q == qsm_pkg::QSM_HOLD && div_q == 8'd0) begin
         cs_n_q <= 1'b1;
      end
   end

   // ****************************************
   // frame sequencer and transmit shifter
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= qsm_pkg::QSM_IDLE;
         sh_q <= 32'h0000_0000;
         cnt_q <= 6'd0;
         words_q <= '0;
      end else if (start) begin
         state_q <= qsm_pkg::QSM_HDR;
         sh_q <= hdr_rev;
         cnt_q <= 6'(qsm_pkg::HDR_BITS - 1);
      end else if (fall_ev && cnt_q != 6'd0) begin
         sh_q <= sh_q >> (6'd1 << lg_run);
         cnt_q <= cnt_q - 6'd1;
      end else if (seg_end) begin
         unique case (state_q)
            qsm_pkg::QSM_HDR: begin
               state_q <= qsm_pkg::QSM_DUM1;
               sh_q <= 32'h0000_0000;
               cnt_q <= 6'((qsm_pkg::DUMMY_BITS >> lg) - 1);
            end
            qsm_pkg::QSM_DUM1, qsm_pkg::QSM_PAY: begin
               if ((state_q == qsm_pkg::QSM_DUM1) ? len_q != '0 : words_q != '0) begin
                  state_q <= qsm_pkg::QSM_PAY;
                  sh_q <= need_word ? rd_s.data : 32'h0000_0000;
                  cnt_q <= 6'((qsm_pkg::WORD_BITS >> lg) - 1);
                  words_q <= (state_q == qsm_pkg::QSM_DUM1) ? len_q - 1'b1 : words_q - 1'b1;
               end else begin
                  state_q <= qsm_pkg::QSM_DUM2;
                  sh_q <= 32'h0000_0000;
                  cnt_q <= 6'((qsm_pkg::DUMMY_BITS >> lg) - 1);
               end
            end
            qsm_pkg::QSM_DUM2: state_q <= qsm_pkg::QSM_HOLD;
            default: ;
         endcase
      end else if (state_q == qsm_pkg::QSM_HOLD && div_q == 8'd0) begin
         state_q <= qsm_pkg::QSM_IDLE;
      end
   end

   // receive and match shifter: samples lanes on the rising edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_sh_q <= 32'h0000_0000;
      end else if (rise_ev && state_q == qsm_pkg::QSM_PAY) begin
         unique case (lg)
            2'd2: rx_sh_q <= {in_s2_q, rx_sh_q[31:4]};
            2'd1: rx_sh_q <= {in_s2_q[1:0], rx_sh_q[31:2]};
            default: rx_sh_q <= {in_s2_q[0], rx_sh_q[31:1]};
         endcase
      end
   end

   // ****************************************
   // output lanes
   // ****************************************
   // first edge phase: lanes follow the shifter, which moves on falls and at start;
   // second edge phase: lanes update on rises and rest low after the frame
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lanes_q <= 4'h0;
      end else if (!active) begin
         lanes_q <= 4'h0;
      end else if (!cpha_q) begin
         lanes_q <= cur_bits;
      end else if (rise_ev) begin
         lanes_q <= cur_bits;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign hrdata = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign sck = sck_q;
   assign cs_n = cs_n_q;
   assign out_lane = lanes_q;
endmodule : qsm_tx_top

// File: qsm_tx_top_monitor.sv
// concurrent checks on the ports of the quad serial master
`timescale 1ns/10ps
module qsm_tx_top_monitor #(
   parameter int SCK_HALF = 4,
   parameter int LEN_W = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [3:0] in_lane,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic [3:0] out_lane
);
   // ****************************************
   // helper state
   // ****************************************
   logic taken;
   logic wr_ctrl_q;
   logic cpha_q;
   logic [3:0] low_cnt_q;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   assign taken = hsel && htrans[1] && hready && hreadyout;

   // shadow of the phase bit, taken in the control write data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ctrl_q <= 1'b0;
         cpha_q <= 1'b0;
      end else begin
         wr_ctrl_q <= taken && hwrite && (haddr == qsm_pkg::OFS_CTRL);
         if (wr_ctrl_q) begin
            cpha_q <= hwdata[qsm_pkg::CTRL_CPHA];
         end
      end
   end

   // cycles of low serial clock, saturating so long idles never wrap
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_cnt_q <= 4'h0;
      end else if (sck) begin
         low_cnt_q <= 4'h0;
      end else if (low_cnt_q != 4'hf) begin
         low_cnt_q <= low_cnt_q + 4'h1;
      end
   end

   property p_okay;
      !hresp;
   endproperty
   a_okay: assert property (p_okay) else $error("error response seen");

   property p_read_nowait;
      taken && !hwrite |=> hreadyout;
   endproperty
   a_read_nowait: assert property (p_read_nowait) else $error("read got a wait state");

   property p_write_wait;
      taken && hwrite |=> !hreadyout;
   endproperty
   a_write_wait: assert property (p_write_wait) else $error("write without wait state");

   property p_sck_idle;
      cs_n |-> !sck;
   endproperty
   a_sck_idle: assert property (p_sck_idle) else $error("clock outside frame");

   property p_start;
      wr_ctrl_q && hwdata[qsm_pkg::CTRL_START] && cs_n &&
         (hwdata[qsm_pkg::CTRL_MODE_LO +: 2] != 2'h0) |-> ##[1:3] !cs_n;
   endproperty
   a_start: assert property (p_start) else $error("start did not open a frame");

   property p_first_rise;
      $fell(cs_n) |-> ##[1:8] $rose(sck);
   endproperty
   a_first_rise: assert property (p_first_rise) else $error("no clock after select");

   property p_low_half;
      $rose(sck) |-> low_cnt_q >= SCK_HALF;
   endproperty
   a_low_half: assert property (p_low_half) else $error("clock low phase short");

   property p_cs_tail;
      $rose(cs_n) |-> !$past(sck) && (low_cnt_q >= SCK_HALF);
   endproperty
   a_cs_tail: assert property (p_cs_tail) else $error("select released early");

   property p_cpha0;
      $rose(sck) && !cpha_q |-> $stable(out_lane);
   endproperty
   a_cpha0: assert property (p_cpha0) else $error("lanes moved on rise");

   property p_cpha1;
      $fell(sck) && cpha_q |-> $stable(out_lane);
   endproperty
   a_cpha1: assert property (p_cpha1) else $error("lanes moved on fall");
endmodule : qsm_tx_top_monitor

// File: qsm_slave_model.sv
// quad slave that logs every lane sample of a frame and returns a fall count
`timescale 1ns/10ps
module qsm_slave_model (
   input wire logic cpha,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic [3:0] out_lane,
   output logic [3:0] in_lane
);
   // ****************************************
   // sampling
   // ****************************************
   logic [3:0] smp[$];

   // sample on the edge opposite the launch edge, only while selected
   always @(posedge sck) if (!cs_n && !cpha) smp.push_back(out_lane);
   always @(negedge sck) if (!cs_n && cpha) smp.push_back(out_lane);

   // the slave sends back a count of falls per frame on in_lane so receive tests can predict
   initial in_lane = 4'h0;
   always @(negedge sck or posedge cs_n) in_lane <= cs_n ? 4'h0 : in_lane + 4'h1;
endmodule : qsm_slave_model

// File: qsm_tx_top_test.sv
// self-checking bench for the quad serial master
`timescale 1ns/10ps
module qsm_tx_top_test;
   // ****************************************
   // signals and instances
   // ****************************************
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, sck, cs_n, cpha;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata;
   logic [3:0] in_lane, out_lane;
   logic [3:0] exp_q[$];
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;

   assign hready = hreadyout;

   qsm_tx_top #(.SCK_HALF(4), .LEN_W(16)) i_qsm_tx_top (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .in_lane(in_lane), .sck(sck), .cs_n(cs_n), .out_lane(out_lane));

   qsm_slave_model i_qsm_slave_model (.cpha(cpha), .sck(sck), .cs_n(cs_n),
      .out_lane(out_lane), .in_lane(in_lane));

   // 100 MHz clock
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   task automatic test_done();
      if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done

   // hang guard, well above the few thousand cycles the tests need
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         test_done();
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // one single transfer; waits only on hready, the timeout ends a hang
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] v;
      bus(1'b1, a, d, v);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      bus(1'b0, a, 32'h0000_0000, v);
      check(v, e);
   endtask : rd_chk

   // queue a payload word and the nibbles it should put on the lanes
   task automatic push(input logic nbs, input logic [31:0] w);
      wr(nbs ? qsm_pkg::OFS_BUF_NBS : qsm_pkg::OFS_BUF, w);
      for (int i = 0; i < 8; i++) exp_q.push_back(w[4 * (nbs ? i ^ 1 : i) +: 4]);
   endtask : push

   task automatic wait_idle();
      logic [31:0] v;
      v = 32'h0000_0001;
      while (v[qsm_pkg::STAT_BUSY] !== 1'b0) bus(1'b0, qsm_pkg::OFS_STAT, 32'h0000_0000, v);
   endtask : wait_idle

   // header on lane 0 msb first, dum dummy clocks each side of the payload
   task automatic chk_frame(input logic [31:0] h, input int dum);
      check(32'(i_qsm_slave_model.smp.size()), 32'(32 + 2 * dum + exp_q.size()));
      if (i_qsm_slave_model.smp.size() == 32 + 2 * dum + exp_q.size()) begin
         for (int i = 0; i < 32; i++)
            check({31'h0, i_qsm_slave_model.smp[i][0]}, {31'h0, h[31 - i]});
         for (int i = 0; i < exp_q.size(); i++)
            check({28'h0, i_qsm_slave_model.smp[32 + dum + i]}, {28'h0, exp_q[i]});
      end
      i_qsm_slave_model.smp.delete();
      exp_q.delete();
   endtask : chk_frame

   // main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      cpha = 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check({26'h0, cs_n, sck, out_lane}, 32'h0000_0020);
      rd_chk(qsm_pkg::OFS_CTRL, 32'h0000_0310);
      rd_chk(qsm_pkg::OFS_HDR, 32'h0000_0000);
      rd_chk(qsm_pkg::OFS_LEN, 32'h0000_0000);
      rd_chk(qsm_pkg::OFS_STAT, 32'h0000_0006);
      wr(8'h20, 32'hFFFF_FFFF);
      rd_chk(8'h20, 32'h0000_0000);
      // start with the shifter off is refused
      wr(qsm_pkg::OFS_CTRL, 32'h0000_0301);
      rd_chk(qsm_pkg::OFS_STAT, 32'h0000_0006);
      check(32'(i_qsm_slave_model.smp.size()), 32'h0000_0000);
      // fill the buffer through both views, then stall a third write
      push(1'b0, 32'h1234_5678);
      rd_chk(qsm_pkg::OFS_BUF_NBS, 32'h2143_6587);
      push(1'b1, 32'h9ABC_DEF0);
      rd_chk(qsm_pkg::OFS_BUF, 32'hA9CB_ED0F);
      rd_chk(qsm_pkg::OFS_STAT, 32'h0000_0000);
      wr(qsm_pkg::OFS_HDR, 32'hA5C3_0F96);
      wr(qsm_pkg::OFS_LEN, 32'h0000_0003);
      wr(qsm_pkg::OFS_CTRL, 32'h0000_0311);
      push(1'b1, 32'h0F1E_2D3C);
      wait_idle();
      chk_frame(32'hA5C3_0F96, 2);
      rd_chk(qsm_pkg::OFS_STAT, 32'h0000_0006);
      // second-edge phase with the payload word arriving late
      cpha <= 1'b1;
      wr(qsm_pkg::OFS_LEN, 32'h0000_0001);
      wr(qsm_pkg::OFS_CTRL, 32'h0000_0313);
      repeat (400) @(posedge hclk);
      check({30'h0, sck, cs_n}, 32'h0000_0002);
      push(1'b1, 32'h8001_7FFE);
      wait_idle();
      chk_frame(32'hA5C3_0F96, 2);
      // dual-lane receive then match; 36 falls precede the payload, so lanes read 0,1,2,3
      cpha <= 1'b0;
      repeat (16) exp_q.push_back(4'h0);
      wr(qsm_pkg::OFS_CTRL, 32'h0000_0121);
      wait_idle();
      chk_frame(32'hA5C3_0F96, 4);
      rd_chk(qsm_pkg::OFS_BUF, 32'hE4E4_E4E4);
      repeat (16) exp_q.push_back(4'h0);
      wr(qsm_pkg::OFS_CTRL, 32'h0000_0131);
      wait_idle();
      chk_frame(32'hA5C3_0F96, 4);
      rd_chk(qsm_pkg::OFS_STAT, 32'h0000_000E);
      wr(qsm_pkg::OFS_STAT, 32'h0000_0008);
      rd_chk(qsm_pkg::OFS_STAT, 32'h0000_0006);
      test_done();
   end
endmodule : qsm_tx_top_test

bind qsm_tx_top qsm_tx_top_monitor #(.SCK_HALF(SCK_HALF), .LEN_W(LEN_W)) i_qsm_tx_top_monitor (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .in_lane(in_lane), .sck(sck), .cs_n(cs_n),
   .out_lane(out_lane));
